// >>> hdl/ufp_defs.svh
// timing counts and constants for the usb parallel fifo port host
`ifndef UFP_DEFS_SVH
`define UFP_DEFS_SVH

`define UFP_CLK_MHZ 250
`define UFP_DATA_W 8
`define UFP_FIFO_DEPTH 8
`define UFP_RD_LOW_NS 50
`define UFP_RD_GAP_NS 50
`define UFP_WR_HIGH_NS 20
`define UFP_WR_LOW_NS 50
`define UFP_WAKE_MS 20
// least times round up to whole cycles
`define UFP_RD_LOW_CYC ((`UFP_RD_LOW_NS * `UFP_CLK_MHZ + 999) / 1000)
`define UFP_RD_GAP_CYC ((`UFP_RD_GAP_NS * `UFP_CLK_MHZ + 999) / 1000)
`define UFP_WR_HIGH_CYC ((`UFP_WR_HIGH_NS * `UFP_CLK_MHZ + 999) / 1000)
`define UFP_WR_LOW_CYC ((`UFP_WR_LOW_NS * `UFP_CLK_MHZ + 999) / 1000)
`define UFP_WAKE_CYC (`UFP_WAKE_MS * 1000 * `UFP_CLK_MHZ)
`define UFP_WAKE_CNT_W 23

`endif

// >>> hdl/ufp_fifo.sv
// small synchronous fifo with registered full and empty
`timescale 1ns/1ps
`default_nettype none
module ufp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] count_reg, count_next;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready <= (count_next != (AW + 1)'(D));
      out_valid <= (count_next != '0);
    end
  end
endmodule
`default_nettype wire

// >>> hdl/ufp_host.sv
// host controller driving the usb parallel fifo port pins
`timescale 1ns/1ps
`default_nettype none
`include "ufp_defs.svh"
module ufp_host import ufp_pkg::*; #(
  parameter int unsigned WAKE_CYC = `UFP_WAKE_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic rd_n,
  output logic wr,
  input wire logic tx_space_flag_n,
  input wire logic rx_flag_in,
  output logic rx_flag_out,
  output logic rx_flag_oe,
  input wire logic power_enable_n,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output ufp_byte_t rx_byte,
  input wire logic wake_req,
  output logic wake_busy,
  output logic suspended
);
  // ---------------------------------------------------------------
  // transmit buffer
  // ---------------------------------------------------------------
  logic fifo_valid, fifo_pop;
  logic [7:0] fifo_data;

  ufp_fifo #(.W(`UFP_DATA_W), .D(`UFP_FIFO_DEPTH)) u_tx_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  ufp_state_t state_reg;
  logic [3:0] tmr_reg;
  logic [`UFP_WAKE_CNT_W-1:0] wake_cnt_reg;
  logic tmr_done, wake_pending_reg, go_read, go_write, go_wake;

  assign tmr_done = (tmr_reg == 4'h0);
  // reads win over writes: the device stalls if received data is never drained
  // read only when data waits
  assign go_read = !power_enable_n && !rx_flag_in;
  assign go_write = !power_enable_n && !tx_space_flag_n && fifo_valid && !go_read;
  assign go_wake = power_enable_n && wake_pending_reg;
  assign fifo_pop = (state_reg == UFP_IDLE) && go_write;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_pending_reg <= 1'b0;
    end else if (wake_req) begin
      wake_pending_reg <= 1'b1;
    end else if (go_wake && state_reg == UFP_IDLE) begin
      wake_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= UFP_IDLE;
      tmr_reg <= 4'h0;
    end else begin
      case (state_reg)
        UFP_IDLE: begin
          if (go_wake) begin
            state_reg <= UFP_WAKE;
          end else if (go_read) begin
            state_reg <= UFP_RD_LOW;
            tmr_reg <= 4'(`UFP_RD_LOW_CYC - 1);
          end else if (go_write) begin
            state_reg <= UFP_WR_HIGH;
            tmr_reg <= 4'(`UFP_WR_HIGH_CYC - 1);
          end
        end
        UFP_RD_LOW: begin
          if (tmr_done) begin
            state_reg <= UFP_RD_GAP;
            tmr_reg <= 4'(`UFP_RD_GAP_CYC - 1);
          end else begin
            tmr_reg <= tmr_reg - 4'h1;
          end
        end
        UFP_WR_HIGH: begin
          // hold write high while no space
          if (tmr_done && !tx_space_flag_n) begin
            state_reg <= UFP_WR_LOW;
            tmr_reg <= 4'(`UFP_WR_LOW_CYC - 1);
          end else if (!tmr_done) begin
            tmr_reg <= tmr_reg - 4'h1;
          end
        end
        UFP_RD_GAP, UFP_WR_LOW: begin
          if (tmr_done) begin
            state_reg <= UFP_IDLE;
          end else begin
            tmr_reg <= tmr_reg - 4'h1;
          end
        end
        UFP_WAKE: begin
          if (wake_cnt_reg == `UFP_WAKE_CNT_W'(WAKE_CYC - 1)) begin
            state_reg <= UFP_IDLE;
          end
        end
        default: begin
          state_reg <= UFP_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read strobe and capture
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_n <= 1'b1;
      rx_byte <= '0;
    end else begin
      rx_byte.valid <= 1'b0;
      if (state_reg == UFP_IDLE && !go_wake && go_read) begin
        rd_n <= 1'b0;
      end else if (state_reg == UFP_RD_LOW && tmr_done) begin
        rd_n <= 1'b1;
        rx_byte.valid <= 1'b1;
        rx_byte.data <= data_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // write strobe and data drive
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr <= 1'b0;
      data_oe <= 1'b0;
      data_out <= 8'h00;
    end else begin
      if (fifo_pop && !go_wake) begin
        wr <= 1'b1;
        data_oe <= 1'b1;
        data_out <= fifo_data;
      end else if (state_reg == UFP_WR_HIGH && tmr_done && !tx_space_flag_n) begin
        wr <= 1'b0;
      end else if (state_reg == UFP_WR_LOW && tmr_done) begin
        data_oe <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // remote wakeup and suspend
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_cnt_reg <= '0;
      rx_flag_oe <= 1'b0;
      rx_flag_out <= 1'b0;
      wake_busy <= 1'b0;
      suspended <= 1'b0;
    end else begin
      // host leaves the strobes idle in suspend: rd_n high, wr low
      suspended <= power_enable_n;
      rx_flag_out <= 1'b0;
      // hold the pin low for the wake time
      if (state_reg == UFP_IDLE && go_wake) begin
        rx_flag_oe <= 1'b1;
        wake_busy <= 1'b1;
        wake_cnt_reg <= '0;
      end else if (state_reg == UFP_WAKE) begin
        if (wake_cnt_reg == `UFP_WAKE_CNT_W'(WAKE_CYC - 1)) begin
          rx_flag_oe <= 1'b0;
          wake_busy <= 1'b0;
        end else begin
          wake_cnt_reg <= wake_cnt_reg + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // wake pulse length counted apart from the sequencer's own counter
  logic [`UFP_WAKE_CNT_W-1:0] oe_len_reg;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_len_reg <= '0;
    end else begin
      oe_len_reg <= rx_flag_oe ? oe_len_reg + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  rd_gate_a: assert property ($fell(rd_n) |-> !$past(rx_flag_in))
    else $error("read strobe asserted without data available");
  rd_sample_a: assert property (
    $rose(rd_n) |-> rx_byte.valid && rx_byte.data == $past(data_in))
    else $error("read data not captured at strobe release");
  rd_width_a: assert property ($fell(rd_n) |-> !rd_n [*8])
    else $error("read strobe too short");
  wr_gate_a: assert property ($fell(wr) |-> !$past(tx_space_flag_n))
    else $error("write completed without tx space");
  wr_block_a: assert property (wr && tx_space_flag_n |=> wr)
    else $error("write strobe fell while tx space high");
  wr_data_a: assert property ($fell(wr) |-> data_oe && $past(data_oe) ##1 data_oe)
    else $error("data not driven around write fall");
  bus_excl_a: assert property (!(data_oe && !rd_n))
    else $error("host drives bus during read");
  wake_len_a: assert property ($fell(rx_flag_oe) |-> oe_len_reg == WAKE_CYC)
    else $error("wake pulse length wrong");
  wake_susp_a: assert property (
    $rose(rx_flag_oe) |-> $past(power_enable_n) && !rx_flag_out)
    else $error("wake driven outside suspend");

  cov_read_c: cover property ($rose(rd_n));
  cov_write_c: cover property ($fell(wr));
  cov_full_c: cover property (!tx_ready && tx_valid);
  cov_wake_c: cover property ($fell(rx_flag_oe));
endmodule
`default_nettype wire

// >>> hdl/ufp_pkg.sv
// types shared by the usb parallel fifo port host
package ufp_pkg;

  typedef enum logic [5:0] {
    UFP_IDLE    = 6'b000001,
    UFP_RD_LOW  = 6'b000010,
    UFP_RD_GAP  = 6'b000100,
    UFP_WR_HIGH = 6'b001000,
    UFP_WR_LOW  = 6'b010000,
    UFP_WAKE    = 6'b100000
  } ufp_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ufp_byte_t;

endpackage

// >>> verification/ufp_dev_model.sv
// behavioural model of the parallel fifo device facing the host
`timescale 1ns/1ps
`default_nettype none
module ufp_dev_model #(
  parameter int WAKE_MIN = 20,
  parameter int FLUSH_MS = 16,
  parameter int MS_CYC = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic rd_n,
  input wire logic wr,
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  input wire logic rx_oe,
  input wire logic rx_out,
  input wire logic stall,
  input wire logic susp,
  output logic [7:0] bus,
  output logic tx_space_flag_n,
  output logic rx_flag,
  output logic power_enable_n
);
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] last = 8'h5a;
  logic [7:0] head = 8'h00;
  logic empty = 1'b1;
  logic wake_seen = 1'b0;
  int viol = 0;
  int low_cnt = 0;
  int flushed = 0;
  int age = 0;
  // flush timeout in whole milliseconds, 1 to 255
  initial if (FLUSH_MS < 1 || FLUSH_MS > 255) viol = viol + 1;
  // buffered bytes reach the host within the flush timeout
  always @(posedge ref_clk) begin
    if (tx_q.size() == flushed) begin
      age <= 0;
    end else if (age + 1 >= FLUSH_MS * MS_CYC) begin
      flushed <= tx_q.size();
      age <= 0;
    end else begin
      age <= age + 1;
    end
  end
  task automatic upd;
    empty = (rx_q.size() == 0);
    head = empty ? last : rx_q[0];
  endtask
  task automatic put(input logic [7:0] v);
    rx_q.push_back(v);
    upd();
  endtask
  assign power_enable_n = susp;
  // floating flags read as pulled up
  assign tx_space_flag_n = sys_rst ? 1'b1 : stall;
  // flag low while data waits, input in suspend
  assign rx_flag = rx_oe ? rx_out : (sys_rst | susp | empty);
  // byte on the bus only while read is low; released bus shows no stale value
  assign bus = host_oe ? host_data : (!rd_n && !empty) ? head : ~last;
  always @(posedge rd_n) begin
    if (!sys_rst && !empty) begin
      last = head;
      void'(rx_q.pop_front());
      upd();
    end
  end
  always @(negedge wr) begin
    if (!sys_rst) begin
      if (tx_space_flag_n) viol++;
      tx_q.push_back(bus);
    end
  end
  // resume request after a long enough low on the flag pin
  always @(posedge ref_clk) begin
    low_cnt <= (susp && rx_oe && !rx_out) ? low_cnt + 1 : 0;
    if (susp && rx_oe && !rx_out && low_cnt + 1 >= WAKE_MIN) wake_seen <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> verification/usb_parallel_fifo_port_tb.sv
// self-checking bench for the parallel fifo port host
`timescale 1ns/1ps
`default_nettype none
module usb_parallel_fifo_port_tb import ufp_pkg::*;;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] data_in, data_out;
  logic [7:0] tx_data = 8'h00;
  logic data_oe, rd_n, wr, tx_space_flag_n, rx_flag_in, rx_flag_out, rx_flag_oe;
  logic power_enable_n, tx_ready, wake_busy, suspended;
  logic tx_valid = 1'b0;
  logic wake_req = 1'b0;
  logic stall = 1'b1;
  logic susp = 1'b0;
  ufp_byte_t rx_byte;
  int bad_count = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] exp_tx[$];
  logic [7:0] exp_rx[$];
  logic [7:0] e;
  initial forever #2 ref_clk = ~ref_clk;
  ufp_host #(.WAKE_CYC(20)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .rd_n(rd_n), .wr(wr),
    .tx_space_flag_n(tx_space_flag_n), .rx_flag_in(rx_flag_in), .rx_flag_out(rx_flag_out),
    .rx_flag_oe(rx_flag_oe), .power_enable_n(power_enable_n), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_byte(rx_byte), .wake_req(wake_req),
    .wake_busy(wake_busy), .suspended(suspended));
  ufp_dev_model #(.WAKE_MIN(20)) m (.ref_clk(ref_clk), .sys_rst(sys_rst), .rd_n(rd_n), .wr(wr),
    .host_data(data_out), .host_oe(data_oe), .rx_oe(rx_flag_oe), .rx_out(rx_flag_out),
    .stall(stall), .susp(susp), .bus(data_in), .tx_space_flag_n(tx_space_flag_n),
    .rx_flag(rx_flag_in), .power_enable_n(power_enable_n));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a refused byte is held unchanged until the fifo takes it or cnt cycles have passed
  task automatic push_tx(input int cnt);
    logic took;
    tx_data = 8'($urandom);
    for (int i = 0; i < cnt; i++) begin
      tx_valid = 1'b1;
      took = (tx_ready === 1'b1);
      if (took) exp_tx.push_back(tx_data);
      step(1);
      if (took) tx_data = 8'($urandom);
    end
    tx_valid = 1'b0;
  endtask
  // waits for the device to hold ntx bytes and all reads to land, stalling at random
  task automatic drain(input int ntx);
    n = 0;
    while ((m.tx_q.size() < ntx || exp_rx.size() > 0) && n < 2000) begin
      stall = 1'(($urandom % 4) == 0);
      step(1);
      n++;
    end
    stall = 1'b0;
    if (n >= 2000) begin
      bad_count++;
      $display("CHECK FAILED at %0t: transfer timeout", $time);
      wrap_up();
    end
    step(30);
    chk(m.tx_q.size() == exp_tx.size(), "written byte count");
    for (int i = 0; i < exp_tx.size(); i++) chk(m.tx_q[i] === exp_tx[i], "written byte");
    chk(m.viol == 0, "write while tx space high");
    chk(m.flushed == m.tx_q.size(), "written bytes flushed to host");
    exp_tx.delete();
    m.tx_q.delete();
  endtask
  always @(negedge ref_clk) begin
    if (!sys_rst && rx_byte.valid === 1'b1) begin
      if (exp_rx.size() == 0) begin
        chk(1'b0, "read with nothing waiting");
      end else begin
        chk(rx_byte.data === exp_rx[0], "read byte");
        void'(exp_rx.pop_front());
      end
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd0b4a65f));
    step(5);
    chk(rd_n === 1'b1 && wr === 1'b0 && data_oe === 1'b0 && rx_flag_oe === 1'b0, "reset");
    sys_rst = 1'b0;
    step(2);
    $display("test reset done");
    push_tx(11);
    chk(exp_tx.size() == 8 && tx_ready === 1'b0, "fifo refusal when full");
    chk(m.tx_q.size() == 0 && wr === 1'b0, "no write while tx space high");
    drain(8);
    $display("test stalled writes done");
    for (int i = 0; i < 6; i++) begin
      e = 8'($urandom);
      exp_rx.push_back(e);
      m.put(e);
    end
    push_tx(3);
    drain(3);
    chk(rx_flag_in === 1'b1 && rd_n === 1'b1, "flag high once empty");
    $display("test mixed reads and writes done");
    susp = 1'b1;
    step(3);
    chk(suspended === 1'b1, "suspend seen");
    wake_req = 1'b1;
    step(1);
    wake_req = 1'b0;
    step(1);
    chk(wake_busy === 1'b1 && rx_flag_oe === 1'b1 && rx_flag_out === 1'b0, "wake drive");
    n = 0;
    while (wake_busy === 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    chk(n < 100 && m.wake_seen === 1'b1 && rx_flag_oe === 1'b0, "wake pulse length");
    $display("test wake done");
    wrap_up();
  end
endmodule
`default_nettype wire
